// ==== hdl/break_guard_map.svh ====
/*
 * Register offsets, field positions and reset values of the break match and latch guard.
 * Assumes it is included by bare name from the design file and the bench.
 */
`ifndef BREAK_GUARD_MAP_SVH
`define BREAK_GUARD_MAP_SVH

// Register offsets on the plain register port.
`define OFS_STATUS_CONTROL 4'h0
`define OFS_ADDR_HIGH 4'h1
`define OFS_ADDR_LOW 4'h2
`define OFS_STATE 4'h3
`define OFS_FLAG_CONTROL 4'h4
`define OFS_IRQ_CONTROL 4'h5
`define OFS_EVT_STATUS 4'h6
`define OFS_EVT_MASK 4'h7

// Field positions.
`define BIT_MATCH_ENABLE 7
`define BIT_ACTIVE_FLAG 6
`define BIT_CLEAR_ENABLE 7
`define BIT_STATE 1
`define BIT_LATCH_ACK 2
`define BIT_LATCH_FLAG 3
`define BIT_EVT_BREAK 0
`define BIT_EVT_LATCH 1

// Reset values.
`define RST_BYTE 8'h00

`endif

// ==== hdl/break_guard_pkg.sv ====
/*
 * Types shared by the break match and latch guard.
 * Assumes the map header sits beside it.
 */
package break_guard_pkg;

    // One access on the register port.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // One CPU bus cycle as seen by the comparator.
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic vectorFetch;
    } bus_cycle_s;

endpackage

// ==== hdl/break_match_and_latch_guard.sv ====
/*
 * Break module: address comparator, break active flag, break interrupt and the guard
 * that decides whether software may clear the external interrupt latch in break state.
 * Assumes one 100 MHz clock, a synchronous register port, and an interrupt request pin
 * that may come from outside the clock domain.
 */
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`include "break_guard_map.svh"

// What this block does
// [RULE1] Enabled full-address match requests a break.
// [RULE2] Enable at bit 7, read/write.
// [RULE3] Active flag set on enabled match.
// [RULE4] Writing one to active flag breaks.
// [RULE5] Software clears active flag before exiting.
// [RULE6] Reset clears enable and active flag.
// [RULE7] Clear enable lets acknowledge clear latch.
// [RULE8] Latch cleared in break stays cleared.
// [RULE9] Clear enable zero protects latch in break.
// [RULE10] Acknowledge outside break clears latch.
// [RULE11] Compare address is high byte over low.
module break_match_and_latch_guard (
    input wire logic clk,
    input wire logic reset_n,
    input wire break_guard_pkg::reg_req_s regReq,
    output logic [7:0] regRdata,
    input wire break_guard_pkg::bus_cycle_s busCycle,
    input wire logic irqPin_n,
    output logic breakRequest,
    output logic breakState,
    output logic latchPending,
    output logic irqOut
);

    // Software-visible state.
    logic matchEnable_reg;
    logic activeFlag_reg;
    logic clearEnable_reg;
    logic stateForce_reg;
    logic [7:0] addrHigh_reg;
    logic [7:0] addrLow_reg;
    logic latch_reg;
    logic [1:0] evtStatus_reg;
    logic [1:0] evtMask_reg;
    logic [7:0] rdata_next;
    // Synchroniser for the external pin and its edge history.
    logic [2:0] pinSync_reg;
    logic pinLevel_reg;

    // Decoded strobes.
    logic wrStatus;
    logic wrIrqCtl;
    logic matchHit;
    logic ackWrite;
    logic ackAllowed;
    logic pinFall;
    logic [1:0] evtSet;

    assign wrStatus = regReq.wr && (regReq.addr == `OFS_STATUS_CONTROL);
    assign wrIrqCtl = regReq.wr && (regReq.addr == `OFS_IRQ_CONTROL);

    // Comparison runs every bus cycle on the concatenated address.
    assign matchHit = matchEnable_reg && busCycle.valid
        && (busCycle.addr == {addrHigh_reg, addrLow_reg}); // [RULE1] [RULE11]

    // Break state lasts while the flag is up; a debugger may also force it.
    // The forced bit lets a debugger hold the latch guard without a recorded match.
    assign breakState = activeFlag_reg || stateForce_reg;

    // A request leaves on a match or on a software write of one to the flag.
    assign breakRequest = matchHit
        || (wrStatus && regReq.wdata[`BIT_ACTIVE_FLAG]); // [RULE1] [RULE4]

    // The acknowledge is honoured unless break state protects the latch.
    assign ackWrite = wrIrqCtl && regReq.wdata[`BIT_LATCH_ACK];
    assign ackAllowed = !breakState || clearEnable_reg; // [RULE7] [RULE9] [RULE10]

    // The pin counts as changed only once the second and third stages agree.
    assign pinFall = (pinSync_reg[1] == pinSync_reg[2]) && !pinSync_reg[2] && pinLevel_reg;

    assign evtSet = {pinFall, breakRequest};

    // Three-stage pin synchroniser; stage 0 feeds only stage 1.
    // Resetting to the pin's idle high level keeps a false edge from following reset.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinSync_reg <= 3'b111;
        end else begin
            pinSync_reg <= {pinSync_reg[1:0], irqPin_n};
        end
    end

    // Last agreed pin level, used to see a falling edge once.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinLevel_reg <= 1'b1;
        end else if (pinSync_reg[1] == pinSync_reg[2]) begin
            pinLevel_reg <= pinSync_reg[2];
        end
    end

    // Enable bit: plain read/write at bit 7, cleared by reset.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            matchEnable_reg <= 1'b0; // [RULE6]
        end else if (wrStatus) begin
            matchEnable_reg <= regReq.wdata[`BIT_MATCH_ENABLE]; // [RULE2]
        end
    end

    // Active flag: a match wins over a simultaneous software clear.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            activeFlag_reg <= 1'b0; // [RULE6]
        end else if (matchHit) begin
            activeFlag_reg <= 1'b1; // [RULE3]
        end else if (wrStatus) begin
            activeFlag_reg <= regReq.wdata[`BIT_ACTIVE_FLAG]; // [RULE4] [RULE5]
        end
    end

    // Break address bytes.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addrHigh_reg <= `RST_BYTE;
            addrLow_reg <= `RST_BYTE;
        end else if (regReq.wr) begin
            if (regReq.addr == `OFS_ADDR_HIGH) begin
                addrHigh_reg <= regReq.wdata;
            end
            if (regReq.addr == `OFS_ADDR_LOW) begin
                addrLow_reg <= regReq.wdata;
            end
        end
    end

    // Flag control and forced break state.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clearEnable_reg <= 1'b0; // [RULE9]
            stateForce_reg <= 1'b0;
        end else if (regReq.wr) begin
            if (regReq.addr == `OFS_FLAG_CONTROL) begin
                clearEnable_reg <= regReq.wdata[`BIT_CLEAR_ENABLE];
            end
            if (regReq.addr == `OFS_STATE) begin
                stateForce_reg <= regReq.wdata[`BIT_STATE];
            end
        end
    end

    // External interrupt latch. A new falling edge beats a same-cycle clear.
    // Nothing reloads it when break state ends, so a clear made in break sticks.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_reg <= 1'b0;
        end else if (pinFall) begin
            latch_reg <= 1'b1;
        end else if ((ackWrite || busCycle.vectorFetch) && ackAllowed) begin
            latch_reg <= 1'b0; // [RULE7] [RULE8] [RULE10]
        end
    end

    // The latch is shown as it is held, with no path around the flip-flop.
    assign latchPending = latch_reg;

    // Sticky event bits; set wins over a write-one clear.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evtStatus_reg <= 2'b00;
        end else if (regReq.wr && regReq.addr == `OFS_EVT_STATUS) begin
            evtStatus_reg <= (evtStatus_reg & ~regReq.wdata[1:0]) | evtSet;
        end else begin
            evtStatus_reg <= evtStatus_reg | evtSet;
        end
    end

    // Event mask.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evtMask_reg <= 2'b00;
        end else if (regReq.wr && regReq.addr == `OFS_EVT_MASK) begin
            evtMask_reg <= regReq.wdata[1:0];
        end
    end

    // One level interrupt, high while any unmasked event bit is kept.
    // It falls only on reset or when software clears the bit or masks it, never on its own.
    assign irqOut = |(evtStatus_reg & evtMask_reg);

    // Read multiplexer; unmapped offsets read zero.
    // Reads have no side effect, so a debugger may poll any register freely.
    always_comb begin
        rdata_next = `RST_BYTE;
        unique case (regReq.addr)
            `OFS_STATUS_CONTROL: begin
                rdata_next[`BIT_MATCH_ENABLE] = matchEnable_reg;
                rdata_next[`BIT_ACTIVE_FLAG] = activeFlag_reg; // [RULE3]
            end
            `OFS_ADDR_HIGH: rdata_next = addrHigh_reg;
            `OFS_ADDR_LOW: rdata_next = addrLow_reg;
            `OFS_STATE: rdata_next[`BIT_STATE] = breakState;
            `OFS_FLAG_CONTROL: rdata_next[`BIT_CLEAR_ENABLE] = clearEnable_reg;
            `OFS_IRQ_CONTROL: rdata_next[`BIT_LATCH_FLAG] = latch_reg;
            `OFS_EVT_STATUS: rdata_next[1:0] = evtStatus_reg;
            `OFS_EVT_MASK: rdata_next[1:0] = evtMask_reg;
            default: rdata_next = `RST_BYTE;
        endcase
    end

    // Read data stand one cycle after the strobe and only then.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= `RST_BYTE;
        end else if (regReq.rd) begin
            regRdata <= rdata_next;
        end else begin
            regRdata <= `RST_BYTE;
        end
    end

    // Checks below watch this block's inputs and its own state. Each one names the rule that
    // it guards; the reset-release check runs without the disable so that it sees
    // the first edge after reset.

    // Enabled match sets the flag on the next edge.
    property p_match_sets_flag;
        @(posedge clk) disable iff (!reset_n) matchHit |=> activeFlag_reg;
    endproperty
    a_match_sets_flag: assert property (p_match_sets_flag) else $error("match lost"); // [RULE3]

    // No request while disabled and no write.
    property p_disabled_quiet;
        @(posedge clk) disable iff (!reset_n)
            (!matchEnable_reg && !wrStatus) |-> !breakRequest;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("break while off"); // [RULE1]

    // Enable follows written bit 7.
    property p_enable_write;
        @(posedge clk) disable iff (!reset_n)
            wrStatus |=> matchEnable_reg == $past(regReq.wdata[7]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable wrong"); // [RULE2]

    // Writing one to the flag requests a break at once.
    property p_soft_break;
        @(posedge clk) disable iff (!reset_n)
            (wrStatus && regReq.wdata[`BIT_ACTIVE_FLAG]) |-> breakRequest;
    endproperty
    a_soft_break: assert property (p_soft_break) else $error("soft break missing"); // [RULE4]

    // Protected acknowledge leaves the latch.
    property p_protect;
        @(posedge clk) disable iff (!reset_n)
            (ackWrite && breakState && !clearEnable_reg && latch_reg) |=> latch_reg;
    endproperty
    a_protect: assert property (p_protect) else $error("latch cleared in break"); // [RULE9]

    // Permitted acknowledge in break clears the latch.
    sequence s_ack_in_break;
        ackWrite && breakState && clearEnable_reg && !pinFall;
    endsequence
    property p_clear_in_break;
        @(posedge clk) disable iff (!reset_n) s_ack_in_break |=> !latch_reg;
    endproperty
    a_clear_in_break: assert property (p_clear_in_break) else $error("no clear"); // [RULE7]

    // A cleared latch rises only on a pin edge, also across break exit.
    property p_stays_clear;
        @(posedge clk) disable iff (!reset_n) (!latch_reg && !pinFall) |=> !latch_reg;
    endproperty
    a_stays_clear: assert property (p_stays_clear) else $error("latch restored"); // [RULE8]

    // Acknowledge outside break clears the latch.
    property p_ack_normal;
        @(posedge clk) disable iff (!reset_n)
            (ackWrite && !breakState && !pinFall) |=> !latch_reg;
    endproperty
    a_ack_normal: assert property (p_ack_normal) else $error("ack ignored"); // [RULE10]

    // Compare uses high byte over low.
    property p_compare;
        @(posedge clk) disable iff (!reset_n)
            (matchEnable_reg && busCycle.valid && busCycle.addr[15:8] == addrHigh_reg
             && busCycle.addr[7:0] == addrLow_reg) |-> breakRequest;
    endproperty
    a_compare: assert property (p_compare) else $error("compare wrong"); // [RULE11]

    // Reset leaves breaks disabled and nothing recorded at the first edge after release.
    sequence s_reset_released;
        $rose(reset_n);
    endsequence
    property p_reset_clears;
        @(posedge clk) s_reset_released |-> (!matchEnable_reg && !activeFlag_reg);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset kept break"); // [RULE6]

    // Without a status write the enable bit keeps its value.
    property p_enable_holds;
        @(posedge clk) disable iff (!reset_n) !wrStatus |=> $stable(matchEnable_reg);
    endproperty
    a_enable_holds: assert property (p_enable_holds) else $error("enable moved"); // [RULE2]

    // A recorded break stays recorded until software writes the flag.
    property p_flag_holds;
        @(posedge clk) disable iff (!reset_n)
            (activeFlag_reg && !wrStatus) |=> activeFlag_reg;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag dropped"); // [RULE3]

    // A write of zero to the flag, with no match beside it, ends the break.
    property p_soft_clear;
        @(posedge clk) disable iff (!reset_n)
            (wrStatus && !regReq.wdata[`BIT_ACTIVE_FLAG] && !matchHit) |=> !activeFlag_reg;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("flag not cleared"); // [RULE5]

    // A vector fetch in protected break state leaves the latch as it is.
    property p_fetch_protect;
        @(posedge clk) disable iff (!reset_n)
            (busCycle.vectorFetch && breakState && !clearEnable_reg && latch_reg) |=> latch_reg;
    endproperty
    a_fetch_protect: assert property (p_fetch_protect) else $error("fetch cleared"); // [RULE9]

    // A vector fetch outside break state clears the latch like the acknowledge.
    property p_fetch_normal;
        @(posedge clk) disable iff (!reset_n)
            (busCycle.vectorFetch && !breakState && !pinFall) |=> !latch_reg;
    endproperty
    a_fetch_normal: assert property (p_fetch_normal) else $error("fetch ignored"); // [RULE10]

    // A matched address is seen twice: the flag rises and the break event is kept.
    sequence s_enabled_match;
        matchHit;
    endsequence
    sequence s_break_recorded;
        activeFlag_reg && evtStatus_reg[`BIT_EVT_BREAK];
    endsequence
    property p_match_recorded;
        @(posedge clk) disable iff (!reset_n) s_enabled_match |=> s_break_recorded;
    endproperty
    a_match_recorded: assert property (p_match_recorded) else $error("match unrecorded"); // [RULE3]

    // A software break always leaves a kept break event for the interrupt logic.
    property p_soft_event;
        @(posedge clk) disable iff (!reset_n)
            (wrStatus && regReq.wdata[`BIT_ACTIVE_FLAG]) |=> evtStatus_reg[`BIT_EVT_BREAK];
    endproperty
    a_soft_event: assert property (p_soft_event) else $error("soft event lost"); // [RULE4]

endmodule // break_match_and_latch_guard

// ==== dv/cpu_bus_model.sv ====
/*
 * CPU core bus model that presents single bus cycles to the break block.
 * Assumes the bench calls its task right after a rising clock edge.
 */
`timescale 1ns/100ps
module cpu_bus_model (
    input wire logic clk,
    output break_guard_pkg::bus_cycle_s busCycle
);
    // The bus starts idle, with nothing valid on it.
    initial busCycle = '0;

    // Drives one bus cycle for exactly one clock, then releases the bus.
    task automatic cycle(input logic [15:0] a, input logic vf);
        busCycle <= '{valid: 1'b1, addr: a, vectorFetch: vf};
        @(posedge clk);
        // The released bus shows the inverse address, so that a stale match cannot pass.
        busCycle <= '{valid: 1'b0, addr: ~a, vectorFetch: 1'b0};
    endtask
endmodule // cpu_bus_model

// ==== dv/break_match_and_latch_guard_tb_top.sv ====
/*
 * Self-checking bench for the break match and latch guard.
 * Assumes the map header and package are compiled first and one 100 MHz clock.
 */
`timescale 1ns/100ps
`include "break_guard_map.svh"
module break_match_and_latch_guard_tb_top;
    logic clk = 1'b0; // Bench clock.
    logic reset_n = 1'b0; // Reset is held for two edges.
    logic irqPin_n = 1'b1; // The pin idles high.
    break_guard_pkg::reg_req_s regReq = '0; // Register port request.
    break_guard_pkg::bus_cycle_s busCycle; // Driven by the CPU model.
    logic [7:0] regRdata;
    logic breakRequest;
    logic breakState;
    logic latchPending;
    logic irqOut;
    int err_total = 0;
    int tests_run = 0;

    // The clock toggles every half period.
    always #5 clk = ~clk;

    break_match_and_latch_guard uut (.clk(clk), .reset_n(reset_n), .regReq(regReq),
        .regRdata(regRdata), .busCycle(busCycle), .irqPin_n(irqPin_n),
        .breakRequest(breakRequest), .breakState(breakState),
        .latchPending(latchPending), .irqOut(irqOut));

    cpu_bus_model bus (.clk(clk), .busCycle(busCycle));

    // Compares one value and counts the result.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        regReq <= '0;
    endtask

    // One-cycle register read; data is only valid in the following cycle.
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        regReq <= '0;
        @(negedge clk);
        chk(regRdata, exp);
    endtask

    // One bus cycle; the break request is combinational, so it is judged mid-cycle.
    task automatic cyc(input logic [15:0] a, input logic vf, input logic expReq);
        @(posedge clk);
        fork
            bus.cycle(a, vf);
            begin
                @(negedge clk);
                chk(breakRequest, expReq);
            end
        join
    endtask

    // Waits a bounded time for the latch; the pin passes a synchroniser first.
    // The first look is a falling edge away, so a value launched on this edge is not read early.
    task automatic waitLatch(input logic exp);
        @(negedge clk);
        for (int i = 0; i < 8 && latchPending !== exp; i++) begin
            @(negedge clk);
        end
        chk(latchPending, exp);
        // A bound used up ends the run at the closing report.
        if (latchPending !== exp) begin
            final_report();
        end
    endtask

    // One falling edge on the pin, held until the latch shows it.
    task automatic pinEdge();
        repeat (4) @(posedge clk);
        irqPin_n <= 1'b0;
        waitLatch(1'b1);
        @(posedge clk);
        irqPin_n <= 1'b1;
    endtask

    // A hang is cut short here and counted.
    initial begin
        #100000;
        err_total++;
        final_report();
    end

    // Reset defaults: breaks off, no break recorded, latch protected in break.
    task automatic scnDefaults();
        rd(`OFS_STATUS_CONTROL, 8'h00);
        rd(`OFS_FLAG_CONTROL, 8'h00);
    endtask

    // Address match: only the full high-over-low address breaks, and it is recorded.
    task automatic scnMatch();
        wr(`OFS_STATUS_CONTROL, 8'h80);
        rd(`OFS_STATUS_CONTROL, 8'h80);
        wr(`OFS_ADDR_HIGH, 8'h12);
        wr(`OFS_ADDR_LOW, 8'h34);
        rd(`OFS_ADDR_HIGH, 8'h12);
        wr(`OFS_EVT_MASK, 8'h01);
        cyc(16'h3412, 1'b0, 1'b0);
        cyc(16'h1235, 1'b0, 1'b0);
        cyc(16'h1234, 1'b0, 1'b1);
        @(negedge clk);
        chk(breakState, 1'b1);
        chk(irqOut, 1'b1);
        rd(`OFS_STATUS_CONTROL, 8'hC0);
        wr(`OFS_EVT_STATUS, 8'h01);
        @(negedge clk);
        chk(irqOut, 1'b0);
    endtask

    // Protected latch in break: neither acknowledge nor vector fetch clears it until allowed.
    task automatic scnLatchInBreak();
        pinEdge();
        wr(`OFS_IRQ_CONTROL, 8'h04);
        cyc(16'h0000, 1'b1, 1'b0);
        @(negedge clk);
        chk(latchPending, 1'b1);
        rd(`OFS_IRQ_CONTROL, 8'h08);
        wr(`OFS_FLAG_CONTROL, 8'h80);
        wr(`OFS_IRQ_CONTROL, 8'h04);
        waitLatch(1'b0);
        wr(`OFS_STATUS_CONTROL, 8'h80);
        @(negedge clk);
        chk(breakState, 1'b0);
        chk(latchPending, 1'b0);
    endtask

    // Outside break state both acknowledge paths clear the latch.
    task automatic scnLatchNormal();
        wr(`OFS_FLAG_CONTROL, 8'h00);
        pinEdge();
        cyc(16'h0000, 1'b1, 1'b0);
        waitLatch(1'b0);
        pinEdge();
        wr(`OFS_IRQ_CONTROL, 8'h04);
        waitLatch(1'b0);
    endtask

    // A forced break state protects the latch just like a recorded break.
    task automatic scnForcedState();
        wr(`OFS_STATE, 8'h02);
        rd(`OFS_STATE, 8'h02);
        chk(breakState, 1'b1);
        pinEdge();
        wr(`OFS_IRQ_CONTROL, 8'h04);
        @(negedge clk);
        chk(latchPending, 1'b1);
        wr(`OFS_STATE, 8'h00);
        wr(`OFS_IRQ_CONTROL, 8'h04);
        waitLatch(1'b0);
    endtask

    // A software break needs no match; with breaks off a match is ignored.
    task automatic scnSoftBreak();
        wr(`OFS_STATUS_CONTROL, 8'h00);
        cyc(16'h1234, 1'b0, 1'b0);
        @(posedge clk);
        regReq <= '{addr: `OFS_STATUS_CONTROL, wdata: 8'hC0, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        chk(breakRequest, 1'b1);
        @(posedge clk);
        regReq <= '0;
        rd(`OFS_STATUS_CONTROL, 8'hC0);
    endtask

    // Reset in mid-run clears the enable, the recorded break and the interrupt output.
    task automatic scnMidReset();
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        rd(`OFS_STATUS_CONTROL, 8'h00);
        chk(breakState, 1'b0);
        chk(irqOut, 1'b0);
    endtask

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        scnDefaults();
        scnMatch();
        scnLatchInBreak();
        scnLatchNormal();
        scnForcedState();
        scnSoftBreak();
        scnMidReset();
        final_report();
    end
endmodule // break_match_and_latch_guard_tb_top
